// ---- design/ucf_defs.vh ----
// Constants for the serial clock and frame core
// Operation
// - Baud counter reloads divisor on zero and on a low divisor byte write.
// - Baud generator pulses once per zero, rate is clock over divisor plus one.
// - Transmitter divides baud pulses by 2, 8 or 16 to form its bit clock.
// - Receiver steps 8 or 16 states per bit from raw baud pulses; sync mode samples one clock edge per bit.
// - Bit rate is clock over 16, 8 or 2 times divisor plus one.
// - Baud divisor is 12 bits from high and low bytes, 0 to 4095.
// - Double speed acts only in asynchronous mode.
// - Double speed gives 8 receive states per bit instead of 16.
// - Sync mode select 0 is asynchronous, 1 is synchronous.
// - In sync mode clock pin direction picks master output or slave input.
// - Transfer clock pin is used only in synchronous mode.
// - Baud generator clocks asynchronous and synchronous master modes.
// - Slave clock passes a synchronizer then an edge detector.
// - Sync receive samples on the edge opposite the transmit change edge.
// - Polarity set: change on falling, sample on rising; cleared swaps edges.
// - Frame: start, 5 to 9 data, none/even/odd parity, 1 or 2 stops.
// - Start bit goes first, then data bits least significant first.
// - Parity bit follows last data bit, ahead of the stop bits.
// - After stops the next frame may follow at once or line idles high.
// - Start bit is always low.
// - Transmitter has one write buffer ahead of its shifter for back to back frames.
// - Receiver has two-level buffer, parity check, flags frame, overrun, parity errors.
// - Three requests: transmit complete, data register empty, receive complete.
// - Stop bits are high and the idle line rests high.
// - Parity is xor of data bits, inverted for odd parity.
// - Receiver checks only the first stop bit for frame error.
`ifndef UCF_DEFS_VH
`define UCF_DEFS_VH
`define UCF_DIV_W 12
`define UCF_DIV_RESET 12'h000
`define UCF_OVS_NORMAL 5'h10
`define UCF_OVS_DOUBLE 5'h08
`define UCF_FRAME_W 13
`define UCF_SIZE_9 3'h7
`define UCF_PAR_NONE 2'h0
`define UCF_PAR_EVEN 2'h2
`define UCF_PAR_ODD 2'h3
`define UCF_ENT_FE 9
`define UCF_ENT_PE 10
`define UCF_ENT_DOR 11
`define UCF_ENT_W 12
`endif

// ---- design/ucf_baud_gen.v ----
// Programmable down-counter baud rate generator
`timescale 1ns/1ps
module ucf_baud_gen #(
  parameter DIV_W = 12
) (
  input wire ref_clk,
  input wire rst,
  input wire [DIV_W-1:0] divisor,
  input wire reload,
  output wire tick
);
  reg [DIV_W-1:0] cnt_q;
  reg [DIV_W-1:0] cnt_d;

  always @* begin
    if (reload || (cnt_q == {DIV_W{1'b0}})) begin
      cnt_d = divisor;
    end else begin
      cnt_d = cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= {DIV_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // One pulse per pass through zero, so the rate is clock over divisor plus one
  assign tick = (cnt_q == {DIV_W{1'b0}}) && !reload;
endmodule // ucf_baud_gen

// ---- design/ucf_core.v ----
// Serial transceiver core: clock modes, frame format, buffers and errors
`timescale 1ns/1ps
`include "ucf_defs.vh"
module ucf_core #(
  parameter DIV_W = `UCF_DIV_W
) (
  input wire ref_clk,
  input wire rst,
  input wire serial0_power_reduction,
  input wire [7:0] baud_divisor_low_byte,
  input wire baud_divisor_low_write,
  input wire [DIV_W-9:0] baud_divisor_high_byte,
  input wire baud_divisor_high_write,
  input wire sync_mode_select,
  input wire double_speed_select,
  input wire transfer_clock_pin_direction,
  input wire sync_clock_polarity,
  input wire [2:0] char_size_select,
  input wire [1:0] parity_mode_select,
  input wire two_stop_select,
  input wire tx_enable,
  input wire rx_enable,
  input wire [8:0] tx_data,
  input wire tx_data_write,
  input wire tx_complete_clear,
  input wire rx_data_read,
  output wire [8:0] serial_data_buffer,
  output wire rx_frame_error,
  output wire rx_parity_error,
  output wire rx_overrun_error,
  output wire irq_tx_complete,
  output wire irq_data_empty,
  output wire irq_rx_complete,
  input wire receive_data_pin,
  output wire transmit_data_pin,
  input wire transfer_clock_pin_in,
  output wire transfer_clock_pin_out,
  output wire transfer_clock_pin_oe
);

  // Number of data bits from the character size code
  function [3:0] data_bits;
    input [2:0] cs;
    begin
      if (cs == `UCF_SIZE_9) begin
        data_bits = 4'h9;
      end else if (cs > 3'h3) begin
        data_bits = 4'h8;
      end else begin
        data_bits = {2'h0, cs[1:0]} + 4'h5;
      end
    end
  endfunction

  // Parity over the low n data bits
  function par_of;
    input [8:0] d;
    input [3:0] n;
    input odd;
    integer i;
    begin
      par_of = odd;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n) begin
          par_of = par_of ^ d[i];
        end
      end
    end
  endfunction

  // Whole frame, bit 0 first on the line; unused upper bits stay high
  function [`UCF_FRAME_W-1:0] frame_of;
    input [8:0] d;
    input [3:0] n;
    input pen;
    input odd;
    integer i;
    begin
      frame_of = {`UCF_FRAME_W{1'b1}};
      frame_of[0] = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n) begin
          frame_of[i+1] = d[i];
        end
      end
      if (pen) begin
        frame_of[n+1] = par_of(d, n, odd);
      end
    end
  endfunction

  // Held in reset while the power reduction bit is set
  wire blk_rst = rst | serial0_power_reduction;

  // Baud divisor and its generator
  reg [7:0] div_lo_q;
  reg [DIV_W-9:0] div_hi_q;
  reg lo_wr_q;
  wire baud_tick;
  wire [DIV_W-1:0] div_rst = `UCF_DIV_RESET;

  always @(posedge ref_clk) begin
    if (rst) begin
      div_lo_q <= div_rst[7:0];
      div_hi_q <= div_rst[DIV_W-1:8];
      lo_wr_q <= 1'b0;
    end else begin
      lo_wr_q <= baud_divisor_low_write;
      if (baud_divisor_low_write) begin
        div_lo_q <= baud_divisor_low_byte;
      end
      // No reload here: the counter picks it up when it next wraps
      if (baud_divisor_high_write) begin
        div_hi_q <= baud_divisor_high_byte;
      end
    end
  end

  // Reload one cycle after the write so the new low byte is already stored
  ucf_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .ref_clk(ref_clk),
    .rst(blk_rst),
    .divisor({div_hi_q, div_lo_q}),
    .reload(lo_wr_q),
    .tick(baud_tick)
  );

  // Mode decode
  wire sync_mode = sync_mode_select;
  wire sync_master = sync_mode & transfer_clock_pin_direction;
  wire dbl_speed = double_speed_select & ~sync_mode;
  wire [4:0] ovs = dbl_speed ? `UCF_OVS_DOUBLE : `UCF_OVS_NORMAL;
  wire [4:0] ovs_last = ovs - 5'h01;
  wire [4:0] ovs_half = {1'b0, ovs[4:1]};
  wire [3:0] n_bits = data_bits(char_size_select);
  wire par_en = parity_mode_select[1];
  wire par_odd = parity_mode_select[0];

  // Transfer clock: master toggles on baud ticks, slave is synchronized
  reg xck_q;
  reg xck_s1_q;
  reg xck_s2_q;
  reg xck_prev_q;
  wire xck_lvl = sync_master ? xck_q : xck_s2_q;

  always @(posedge ref_clk) begin
    if (blk_rst) begin
      xck_q <= 1'b0;
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      xck_prev_q <= 1'b0;
    end else begin
      xck_s1_q <= transfer_clock_pin_in;
      xck_s2_q <= xck_s1_q;
      xck_prev_q <= xck_lvl;
      // Two ticks per transfer clock period gives the divide by 2
      if (sync_master && baud_tick) begin
        xck_q <= ~xck_q;
      end else if (!sync_master) begin
        xck_q <= 1'b0;
      end
    end
  end

  wire xck_rise = xck_lvl & ~xck_prev_q;
  wire xck_fall = ~xck_lvl & xck_prev_q;
  // Pin edges only count in synchronous mode
  wire chg_edge = sync_mode & (sync_clock_polarity ? xck_fall : xck_rise);
  wire smp_edge = sync_mode & (sync_clock_polarity ? xck_rise : xck_fall);

  assign transfer_clock_pin_out = xck_q;
  assign transfer_clock_pin_oe = sync_master;

  // Transmit bit clock
  reg [4:0] txdiv_q;

  always @(posedge ref_clk) begin
    if (blk_rst) begin
      txdiv_q <= 5'h00;
    end else if (baud_tick) begin
      if (txdiv_q >= ovs_last) begin
        txdiv_q <= 5'h00;
      end else begin
        txdiv_q <= txdiv_q + 5'h01;
      end
    end
  end

  wire tx_evt = sync_mode ? chg_edge : (baud_tick && (txdiv_q == ovs_last));

  // Transmitter: one write buffer in front of the shifter
  reg [8:0] tx_buf_q;
  reg tx_buf_full_q;
  reg [`UCF_FRAME_W-1:0] tx_sr_q;
  reg [3:0] tx_left_q;
  reg tx_busy_q;
  reg tx_line_q;
  reg tx_done_q;
  wire [`UCF_FRAME_W-1:0] tx_frame = frame_of(tx_buf_q, n_bits, par_en, par_odd);
  wire [3:0] tx_len = 4'h1 + n_bits + {3'h0, par_en} + {3'h0, two_stop_select} + 4'h1;
  wire tx_load = tx_evt && (tx_left_q == 4'h0) && tx_buf_full_q && tx_enable;
  wire tx_finish = tx_evt && (tx_left_q == 4'h0) && !tx_load && tx_busy_q;
  // Writes while the buffer is full are dropped; software polls the empty flag
  wire tx_accept = tx_data_write && tx_enable && !tx_buf_full_q;

  always @(posedge ref_clk) begin
    if (blk_rst) begin
      tx_buf_q <= 9'h000;
      tx_buf_full_q <= 1'b0;
    end else begin
      if (tx_accept) begin
        tx_buf_q <= tx_data;
        tx_buf_full_q <= 1'b1;
      end else if (tx_load) begin
        tx_buf_full_q <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (blk_rst) begin
      tx_sr_q <= {`UCF_FRAME_W{1'b1}};
      tx_left_q <= 4'h0;
      tx_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (tx_evt) begin
      if (tx_left_q != 4'h0) begin
        tx_line_q <= tx_sr_q[0];
        tx_sr_q <= {1'b1, tx_sr_q[`UCF_FRAME_W-1:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end else if (tx_load) begin
        // Next frame starts straight after the last stop bit
        tx_line_q <= tx_frame[0];
        tx_sr_q <= {1'b1, tx_frame[`UCF_FRAME_W-1:1]};
        tx_left_q <= tx_len - 4'h1;
        tx_busy_q <= 1'b1;
      end else begin
        tx_line_q <= 1'b1;
        tx_busy_q <= 1'b0;
      end
    end
  end

  // Completion flag: a new completion beats a clear in the same cycle
  always @(posedge ref_clk) begin
    if (blk_rst) begin
      tx_done_q <= 1'b0;
    end else if (tx_finish) begin
      tx_done_q <= 1'b1;
    end else if (tx_complete_clear) begin
      tx_done_q <= 1'b0;
    end
  end

  assign transmit_data_pin = tx_line_q;

  // Receiver: pin synchronizer
  reg rxd_s1_q;
  reg rxd_s2_q;

  always @(posedge ref_clk) begin
    if (blk_rst) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= receive_data_pin;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // Receiver frame state
  reg rx_act_q;
  reg [4:0] rx_ph_q;
  reg [3:0] rx_idx_q;
  reg [8:0] rx_sh_q;
  reg rx_par_q;
  wire [3:0] rx_par_idx = n_bits + 4'h1;
  wire [3:0] rx_stop_idx = rx_par_idx + {3'h0, par_en};
  // Async: ovs states per bit; sync: one sample edge per bit
  wire rx_smp = rx_act_q &&
    (sync_mode ? smp_edge : (baud_tick && (rx_ph_q == ovs_half)));
  wire rx_start_async = !sync_mode && baud_tick && !rxd_s2_q;
  wire rx_start_sync = sync_mode && smp_edge && !rxd_s2_q;
  wire rx_done = rx_smp && (rx_idx_q == rx_stop_idx);
  wire [8:0] rx_word = rx_sh_q >> (4'h9 - n_bits);

  always @(posedge ref_clk) begin
    if (blk_rst || !rx_enable) begin
      rx_act_q <= 1'b0;
      rx_ph_q <= 5'h00;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_par_q <= 1'b0;
    end else if (!rx_act_q) begin
      if (rx_start_async) begin
        rx_act_q <= 1'b1;
        rx_ph_q <= 5'h00;
        rx_idx_q <= 4'h0;
      end else if (rx_start_sync) begin
        rx_act_q <= 1'b1;
        rx_idx_q <= 4'h1;
      end
    end else begin
      if (baud_tick) begin
        rx_ph_q <= (rx_ph_q >= ovs_last) ? 5'h00 : rx_ph_q + 5'h01;
      end
      if (rx_smp) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0) begin
          // A start bit that has gone high by mid-bit was noise
          if (rxd_s2_q) begin
            rx_act_q <= 1'b0;
          end
        end else if (rx_idx_q <= n_bits) begin
          rx_sh_q <= {rxd_s2_q, rx_sh_q[8:1]};
        end else if (par_en && (rx_idx_q == rx_par_idx)) begin
          rx_par_q <= rxd_s2_q;
        end
        // Done after the first stop; a second stop bit is never looked at
        if (rx_done) begin
          rx_act_q <= 1'b0;
        end
      end
    end
  end

  // Entry for the receive buffer
  wire rx_fe = ~rxd_s2_q;
  wire rx_pe = par_en && (rx_par_q != par_of(rx_word, n_bits, par_odd));
  wire [`UCF_ENT_W-1:0] rx_entry = {1'b0, rx_pe, rx_fe, rx_word};

  // Two-level receive buffer: head is what software sees
  reg [`UCF_ENT_W-1:0] rb_head_q;
  reg [`UCF_ENT_W-1:0] rb_head_d;
  reg [`UCF_ENT_W-1:0] rb_tail_q;
  reg [`UCF_ENT_W-1:0] rb_tail_d;
  reg rb_hv_q;
  reg rb_hv_d;
  reg rb_tv_q;
  reg rb_tv_d;

  always @* begin
    rb_head_d = rb_head_q;
    rb_tail_d = rb_tail_q;
    rb_hv_d = rb_hv_q;
    rb_tv_d = rb_tv_q;
    if (rx_data_read && rb_hv_q) begin
      rb_head_d = rb_tail_q;
      rb_hv_d = rb_tv_q;
      rb_tv_d = 1'b0;
    end
    if (rx_done) begin
      if (!rb_hv_d) begin
        rb_head_d = rx_entry;
        rb_hv_d = 1'b1;
      end else if (!rb_tv_d) begin
        rb_tail_d = rx_entry;
        rb_tv_d = 1'b1;
      end else begin
        // Both levels full: new frame lost, flagged on the newest unread one
        rb_tail_d[`UCF_ENT_DOR] = 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (blk_rst) begin
      rb_head_q <= {`UCF_ENT_W{1'b0}};
      rb_tail_q <= {`UCF_ENT_W{1'b0}};
      rb_hv_q <= 1'b0;
      rb_tv_q <= 1'b0;
    end else begin
      rb_head_q <= rb_head_d;
      rb_tail_q <= rb_tail_d;
      rb_hv_q <= rb_hv_d;
      rb_tv_q <= rb_tv_d;
    end
  end

  assign serial_data_buffer = rb_head_q[8:0];
  assign rx_frame_error = rb_head_q[`UCF_ENT_FE];
  assign rx_parity_error = rb_head_q[`UCF_ENT_PE];
  assign rx_overrun_error = rb_head_q[`UCF_ENT_DOR];

  // Request lines to the interrupt controller
  assign irq_tx_complete = tx_done_q;
  assign irq_data_empty = tx_enable & ~tx_buf_full_q;
  assign irq_rx_complete = rb_hv_q;
endmodule // ucf_core

// ---- verification/ucf_core_chk.sv ----
// Assertion checker watching the serial clock and frame core ports
`timescale 1ns/1ps
module ucf_core_chk (
  input wire ref_clk,
  input wire rst,
  input wire serial0_power_reduction,
  input wire sync_mode_select,
  input wire transfer_clock_pin_direction,
  input wire tx_enable,
  input wire rx_enable,
  input wire tx_data_write,
  input wire tx_complete_clear,
  input wire rx_data_read,
  input wire irq_tx_complete,
  input wire irq_data_empty,
  input wire irq_rx_complete,
  input wire transmit_data_pin,
  input wire transfer_clock_pin_out,
  input wire transfer_clock_pin_oe
);
  wire sm_now;
  reg sm_q;
  assign sm_now = sync_mode_select & transfer_clock_pin_direction;
  // Registered clock output lags a mode change by one cycle
  always @(posedge ref_clk) begin
    sm_q <= sm_now;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst_idle;
    disable iff (1'b0) rst |=> transmit_data_pin && !irq_tx_complete && !irq_rx_complete;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line or flags wrong after reset");
  property p_empty_drop;
    tx_data_write && irq_data_empty && !serial0_power_reduction |=> !irq_data_empty;
  endproperty
  a_empty_drop: assert property (p_empty_drop) else $error("write buffer not taken");
  property p_oe;
    transfer_clock_pin_oe == sm_now;
  endproperty
  a_oe: assert property (p_oe) else $error("clock pin enable wrong for mode");
  property p_clk_idle;
    !sm_now && !sm_q |-> !transfer_clock_pin_out;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock out active outside master");
  property p_txc_clear;
    $fell(irq_tx_complete) |->
      $past(tx_complete_clear) || $past(serial0_power_reduction) || !$past(tx_enable);
  endproperty
  a_txc_clear: assert property (p_txc_clear) else $error("tx complete fell without clear");
  property p_rxc_clear;
    $fell(irq_rx_complete) |->
      $past(rx_data_read) || $past(serial0_power_reduction) || !$past(rx_enable);
  endproperty
  a_rxc_clear: assert property (p_rxc_clear) else $error("rx complete fell without read");
  property p_txc_idle;
    $rose(irq_tx_complete) |-> transmit_data_pin;
  endproperty
  a_txc_idle: assert property (p_txc_idle) else $error("line not idle at tx complete");
  // Shortest async bit is 8 cycles: double speed with divisor zero
  property p_bit_min;
    $fell(transmit_data_pin) && !sync_mode_select && tx_enable |->
      ##1 (!transmit_data_pin || serial0_power_reduction || !tx_enable)[*7];
  endproperty
  a_bit_min: assert property (p_bit_min) else $error("async low bit too short");
endmodule // ucf_core_chk

bind ucf_core ucf_core_chk u_chk (
  .ref_clk, .rst, .serial0_power_reduction, .sync_mode_select,
  .transfer_clock_pin_direction, .tx_enable, .rx_enable, .tx_data_write,
  .tx_complete_clear, .rx_data_read, .irq_tx_complete, .irq_data_empty,
  .irq_rx_complete, .transmit_data_pin, .transfer_clock_pin_out, .transfer_clock_pin_oe
);

// ---- verification/ucf_peer.sv ----
// Behavioural peer transceiver on the core's serial line side
`timescale 1ns/1ps
module ucf_peer (
  input wire ref_clk,
  input wire txd,
  input wire xck,
  output reg rxd
);
  initial rxd = 1'b1;
  task stp(input sy, input integer bt);
    begin
      if (sy) @(posedge xck);
      else repeat (bt) @(negedge ref_clk);
    end
  endtask
  task send(input [8:0] w, input integer n, bt, input [1:0] pm, input bp, bs);
    integer k;
    begin
      rxd = 1'b0;
      repeat (bt) @(negedge ref_clk);
      for (k = 0; k < n; k = k + 1) begin
        rxd = w[k];
        repeat (bt) @(negedge ref_clk);
      end
      if (pm[1]) begin
        rxd = ^(w & (9'h1ff >> (9 - n))) ^ pm[0] ^ bp;
        repeat (bt) @(negedge ref_clk);
      end
      rxd = !bs;
      repeat (bt) @(negedge ref_clk);
      // Left high here so that a following frame may start at once
      if (bs) rxd = 1'b1;
    end
  endtask
  task get(input integer n, bt, ns, input [1:0] pm, input sy, output [8:0] w, output p, s,
    output integer wt);
    integer k;
    begin
      w = 9'h000;
      p = 1'b0;
      s = 1'b1;
      wt = 0;
      if (sy) begin
        @(posedge xck);
        while (txd && wt < 300) begin
          @(posedge xck);
          wt = wt + 1;
        end
      end else begin
        // Falling edge: the line is launched on the rising edge and settled here
        while (txd && wt < 9000) begin
          @(negedge ref_clk);
          wt = wt + 1;
        end
        repeat (bt / 2) @(negedge ref_clk);
      end
      for (k = 0; k < n; k = k + 1) begin
        stp(sy, bt);
        w[k] = txd;
      end
      if (pm[1]) begin
        stp(sy, bt);
        p = txd;
      end
      for (k = 0; k < ns; k = k + 1) begin
        stp(sy, bt);
        s = s & txd;
      end
    end
  endtask
endmodule // ucf_peer

// ---- verification/ucf_core_tb_top.sv ----
// Self-checking testbench for the serial clock and frame core
`timescale 1ns/1ps
module ucf_core_tb_top;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] lo = 8'h00;
  reg [3:0] hi = 4'h0;
  reg lo_w = 1'b0, hi_w = 1'b0, sm = 1'b0, ds = 1'b0, dir = 1'b0, st2 = 1'b0;
  reg txw = 1'b0, tcc = 1'b0, rdd = 1'b0, ext_run = 1'b0, ext_clk = 1'b0, pol = 1'b1;
  reg [2:0] cs = 3'h3;
  reg [1:0] pm = 2'h0;
  reg [8:0] td = 9'h000, w, gw;
  reg gp, gs;
  wire [8:0] sbuf;
  wire fe, pe, ovr, txc, dre, rxc, rxd, txd, xo, xoe, xck;
  integer err_total = 0, cmp_count = 0, cyc = 0, k, n, bt, wt;
  time t0;
  assign xck = xoe ? xo : ext_clk;
  always #25 ref_clk = ~ref_clk;
  // Slave clock period of 16 cycles keeps well under a quarter of the system clock
  always begin
    repeat (8) @(negedge ref_clk);
    if (ext_run) ext_clk <= ~ext_clk;
  end
  ucf_core u_dut (
    .ref_clk(ref_clk), .rst(rst), .serial0_power_reduction(1'b0),
    .baud_divisor_low_byte(lo), .baud_divisor_low_write(lo_w),
    .baud_divisor_high_byte(hi), .baud_divisor_high_write(hi_w),
    .sync_mode_select(sm), .double_speed_select(ds), .transfer_clock_pin_direction(dir),
    .sync_clock_polarity(pol), .char_size_select(cs), .parity_mode_select(pm),
    .two_stop_select(st2), .tx_enable(1'b1), .rx_enable(1'b1), .tx_data(td),
    .tx_data_write(txw), .tx_complete_clear(tcc), .rx_data_read(rdd),
    .serial_data_buffer(sbuf), .rx_frame_error(fe), .rx_parity_error(pe),
    .rx_overrun_error(ovr), .irq_tx_complete(txc), .irq_data_empty(dre),
    .irq_rx_complete(rxc), .receive_data_pin(rxd), .transmit_data_pin(txd),
    .transfer_clock_pin_in(ext_clk), .transfer_clock_pin_out(xo), .transfer_clock_pin_oe(xoe)
  );
  // Peer samples on its rising edge, so it sees the clock inverted when polarity is clear
  ucf_peer u_peer (.ref_clk(ref_clk), .txd(txd), .xck(xck ~^ pol), .rxd(rxd));
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk_v(input [8:0] g, e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_b(input g, e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: bit %b expected %b", $time, g, e);
      end
    end
  endtask
  task wr(input [8:0] d);
    begin
      td = d;
      txw = 1'b1;
      @(negedge ref_clk);
      txw = 1'b0;
    end
  endtask
  task rd;
    begin
      rdd = 1'b1;
      @(negedge ref_clk);
      rdd = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  // One idle edge first so a strobe never rises in the step that lowered it
  task wait_hi(input sel);
    integer i;
    begin
      @(negedge ref_clk);
      for (i = 0; i < 4000 && (sel ? rxc : dre) !== 1'b1; i = i + 1) @(negedge ref_clk);
    end
  endtask
  function [8:0] msk(input integer m);
    msk = 9'h1ff >> (9 - m);
  endfunction
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    chk_b(txd, 1'b1);
    chk_b(dre, 1'b1);
    chk_b(xoe, 1'b0);
    $display("Test reset done");
    hi_w = 1'b1;
    @(negedge ref_clk);
    hi_w = 1'b0;
    lo = 8'h01;
    lo_w = 1'b1;
    @(negedge ref_clk);
    lo_w = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      n = 5 + k % 5;
      cs = (n == 9) ? 3'h7 : n[2:0] - 3'h5;
      pm = (k % 3 == 0) ? 2'h0 : (k % 3 == 1) ? 2'h2 : 2'h3;
      sm = k > 5;
      dir = k == 6;
      ds = k == 5;
      ext_run = k == 7;
      pol = k != 7;
      st2 = k[0];
      bt = ds ? 16 : 32;
      w = 9'h0b5 + k * 75;
      @(negedge ref_clk);
      if (k == 6) begin
        @(posedge xck);
        t0 = $time;
        @(posedge xck);
        chk_v(($time - t0) / 50, 9'h004);
        @(negedge ref_clk);
      end
      wr(w);
      u_peer.get(n, bt, st2 + 1, pm, sm, gw, gp, gs, wt);
      chk_v(gw, w & msk(n));
      chk_b(gp, pm[1] ? ^(w & msk(n)) ^ pm[0] : 1'b0);
      chk_b(gs, 1'b1);
      repeat (bt) @(negedge ref_clk);
      chk_b(txc, 1'b1);
      tcc = 1'b1;
      @(negedge ref_clk);
      tcc = 1'b0;
      @(negedge ref_clk);
      chk_b(txc, 1'b0);
    end
    $display("Test transmit formats and modes done");
    {sm, dir, ds, ext_run, st2, cs, pm} = {5'h00, 3'h3, 2'h0};
    wr(9'h03c);
    wait_hi(1'b0);
    wr(9'h0c3);
    u_peer.get(8, 32, 1, 2'h0, 1'b0, gw, gp, gs, wt);
    chk_v(gw, 9'h03c);
    u_peer.get(8, 32, 1, 2'h0, 1'b0, gw, gp, gs, wt);
    chk_v(gw, 9'h0c3);
    chk_b(wt <= 18, 1'b1);
    $display("Test back to back transmit done");
    for (k = 0; k < 5; k = k + 1) begin
      n = 5 + k;
      cs = (n == 9) ? 3'h7 : n[2:0] - 3'h5;
      pm = (k % 3 == 0) ? 2'h0 : (k % 3 == 1) ? 2'h2 : 2'h3;
      ds = k == 4;
      bt = ds ? 16 : 32;
      w = 9'h1d3 - k * 59;
      @(negedge ref_clk);
      u_peer.send(w, n, bt, pm, k == 1, k == 2);
      wait_hi(1'b1);
      chk_b(rxc, 1'b1);
      chk_v(sbuf, w & msk(n));
      chk_b(pe, k == 1);
      chk_b(fe, k == 2);
      chk_b(ovr, 1'b0);
      rd;
    end
    $display("Test receive formats and errors done");
    {ds, cs, pm} = {1'b0, 3'h3, 2'h0};
    for (k = 0; k < 3; k = k + 1) u_peer.send(9'h021 + k, 8, 32, 2'h0, 1'b0, 1'b0);
    repeat (40) @(negedge ref_clk);
    chk_v(sbuf, 9'h021);
    chk_b(ovr, 1'b0);
    rd;
    chk_v(sbuf, 9'h022);
    chk_b(ovr, 1'b1);
    rd;
    chk_b(rxc, 1'b0);
    $display("Test receive overrun done");
    give_verdict;
  end
endmodule // ucf_core_tb_top
